// File: core/pws_slave.sv
// Two-wire serial slave port of a 256-position digital potentiometer.
`timescale 1ns/1ps

// How it works
// (RULE1) Address is 010110 plus strap level.
// (RULE2) First byte: address, direction, MSB first.
// (RULE3) Master opens each transfer with START.
// (RULE4) Matching address acknowledged on ninth pulse.
// (RULE5) Direction one reads, zero writes.
// (RULE6) Write: instruction byte, outer bits ignored.
// (RULE7) Midscale reset bit overwrites wiper register.
// (RULE8) Shutdown opens A, ties wiper to B.
// (RULE9) Shutdown keeps register; stored value reapplied after.
// (RULE10) Writes still stored during shutdown.
// (RULE11) Data byte follows instruction; nine clocks each.
// (RULE12) Data line changes only while clock low.
// (RULE13) Read sends wiper bits MSB first immediately.
// (RULE14) Read returns current wiper register.
// (RULE15) Master ends each transfer with STOP.
// (RULE16) Master NACKs last read byte, then STOP.
// (RULE17) Further write bytes reload wiper, same instruction.
// (RULE18) New instruction needs a new write transfer.
// (RULE19) Repeated reads while master keeps acknowledging.
// (RULE20) Distinct strap levels give independent devices.
// (RULE21) Midscale code is hexadecimal 80.
// (RULE22) Wiper register presets to midscale.
// (RULE23) Eight-bit wiper selects one of 256 taps.
// (RULE24) Mismatch releases line, ignores until START.
module pws_slave
    import pws_pkg::*;
(
    // Clock and asynchronous active-low reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Serial bus pins; the data line is open drain.
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe,
    // Address select strap pin.
    input  wire logic                 address_select_strap,
    // Wiper state.
    output logic [WIPER_W-1:0]        wiper_register,
    output logic                      shutdown_active,
    output logic                      addressed,
    // Ladder switch controls.
    output logic [TAP_COUNT-1:0]      tap_select,
    output logic                      term_a_open,
    output logic                      wiper_to_b
);

    // Reset release synchroniser.
    logic [1:0]         rst_sync_ff;  // Release shift chain.
    logic               rst_ns;       // Synchronised reset used everywhere.

    // Synchronised pins and their one-cycle delayed copies.
    logic               scl_s;        // Clock line after two flops.
    logic               sda_s;        // Data line after two flops.
    logic               strap_s;      // Strap after two flops.
    logic               scl_q_ff;     // Clock line one cycle older.
    logic               sda_q_ff;     // Data line one cycle older.

    // Bus events.
    logic               scl_rise;     // Clock line went high.
    logic               scl_fall;     // Clock line went low.
    logic               start_det;    // START seen.
    logic               stop_det;     // STOP seen.
    logic               byte_done;    // Eighth data bit sampled.
    logic [7:0]         rx_byte;      // Byte including the bit now sampled.

    // Serial engine state.
    pws_state_t         state_ff;     // Current engine state.
    logic [3:0]         bit_cnt_ff;   // Data bits clocked in this byte.
    logic [7:0]         shift_ff;     // Receive or transmit shifter.
    logic               sda_oe_ff;    // Pulling the data line low.
    logic               read_ack_ff;  // Master acknowledged the read byte.
    logic               sda_out_ff;   // Level driven when enabled.

    // Stored instruction and wiper.
    logic               rs_mode_ff;   // Midscale reset bit of the instruction.
    logic               shutdown_ff;  // Shutdown bit of the instruction.
    logic [WIPER_W-1:0] wiper_ff;     // The wiper register.
    logic               addressed_ff; // A transfer to this device is open.

    // Address compare against the fixed upper bits and the strap.
    function automatic logic addr_match(input logic [6:0] addr, input logic strap);
        addr_match = (addr == {ADDR_UPPER, strap});  // [RULE1] [RULE20]
    endfunction

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
        end
    end

    assign rst_ns = rst_sync_ff[1];

    // Synchronisers for the clock line, data line and strap.
    pws_sync #(.RST_VAL(LINE_IDLE)) u_sync_scl (
        .ref_clk  (ref_clk),
        .rst_n    (rst_ns),
        .async_in (scl_i),
        .sync_out (scl_s)
    );

    pws_sync #(.RST_VAL(LINE_IDLE)) u_sync_sda (
        .ref_clk  (ref_clk),
        .rst_n    (rst_ns),
        .async_in (sda_i),
        .sync_out (sda_s)
    );

    pws_sync #(.RST_VAL(STRAP_RST)) u_sync_strap (
        .ref_clk  (ref_clk),
        .rst_n    (rst_ns),
        .async_in (address_select_strap),
        .sync_out (strap_s)
    );

    // Delayed copies for edge detection on the synchronised lines.
    always_ff @(posedge ref_clk or negedge rst_ns) begin
        if (!rst_ns) begin
            scl_q_ff <= LINE_IDLE;
            sda_q_ff <= LINE_IDLE;
        end else begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
        end
    end

    // Data is sampled on the clock rise and changed after the clock fall.
    assign scl_rise  = scl_s & ~scl_q_ff;
    assign scl_fall  = ~scl_s & scl_q_ff;
    // A data edge while the clock stays high frames a transfer.
    assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;  // [RULE3]
    assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;  // [RULE15]
    assign byte_done = scl_rise & (bit_cnt_ff == BIT_LAST);   // [RULE11]
    assign rx_byte   = {shift_ff[6:0], sda_s};                // [RULE2]

    // Serial engine: byte framing, acknowledge and read data.
    always_ff @(posedge ref_clk or negedge rst_ns) begin
        if (!rst_ns) begin
            state_ff    <= ST_IDLE;
            bit_cnt_ff  <= 4'h0;
            shift_ff    <= 8'h00;
            sda_oe_ff   <= 1'h0;
            read_ack_ff <= 1'h0;
        end else if (start_det) begin
            // A START, repeated or not, always restarts address reception.
            state_ff   <= ST_ADDR;  // [RULE24]
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'h0;
        end else if (stop_det) begin
            // STOP closes any transfer and frees the line.
            state_ff   <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'h0;
        end else begin
            case (state_ff)
                ST_ADDR, ST_INSTR, ST_WDATA: begin
                    // Shift in a byte MSB first on clock rises.
                    if (scl_rise) begin
                        shift_ff   <= rx_byte;  // [RULE2]
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == ST_INSTR) begin
                            state_ff <= ST_INSTR_ACK;
                        end else if (state_ff == ST_WDATA) begin
                            state_ff <= ST_WDATA_ACK;
                        end else if (addr_match(rx_byte[7:1], strap_s)) begin
                            state_ff <= ST_ADDR_ACK;  // [RULE4]
                        end else begin
                            state_ff <= ST_IGNORE;    // [RULE24] [RULE4]
                        end
                    end
                end
                ST_ADDR_ACK, ST_INSTR_ACK, ST_WDATA_ACK: begin
                    // First fall pulls low for the ninth pulse; second releases, or on a read drives the first data bit.
                    if (scl_fall) begin
                        if (!sda_oe_ff) begin
                            sda_oe_ff <= 1'h1;  // [RULE4] [RULE12]
                        end else if (state_ff == ST_ADDR_ACK && shift_ff[0]) begin
                            // Read: first data bit goes out at once.
                            state_ff   <= ST_RDATA;    // [RULE5] [RULE13]
                            shift_ff   <= wiper_ff;    // [RULE14]
                            sda_oe_ff  <= ~wiper_ff[WIPER_W-1];
                            bit_cnt_ff <= 4'h0;
                        end else if (state_ff == ST_ADDR_ACK) begin
                            state_ff  <= ST_INSTR;     // [RULE5] [RULE6]
                            sda_oe_ff <= 1'h0;
                        end else begin
                            // Instruction and data bytes are followed by data.
                            state_ff  <= ST_WDATA;     // [RULE11] [RULE17]
                            sda_oe_ff <= 1'h0;
                        end
                    end
                end
                ST_RDATA: begin
                    // Count rises; move to the next bit after each fall.
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (scl_fall) begin
                        if (bit_cnt_ff == BYTE_BITS) begin
                            sda_oe_ff <= 1'h0;  // Master owns the ninth pulse.
                            state_ff  <= ST_RDATA_ACK;
                        end else if (bit_cnt_ff != 4'h0) begin
                            sda_oe_ff <= ~shift_ff[6];  // [RULE13] [RULE12]
                            shift_ff  <= {shift_ff[6:0], 1'h0};
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    // Low on the ninth pulse asks for another byte.
                    if (scl_rise) begin
                        read_ack_ff <= ~sda_s;
                    end
                    if (scl_fall) begin
                        if (read_ack_ff) begin
                            state_ff   <= ST_RDATA;   // [RULE19]
                            shift_ff   <= wiper_ff;   // [RULE14]
                            sda_oe_ff  <= ~wiper_ff[WIPER_W-1];
                            bit_cnt_ff <= 4'h0;
                        end else begin
                            // Not acknowledged: wait for the closing STOP.
                            state_ff <= ST_IGNORE;    // [RULE16]
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    // Line released; only START or STOP matter here.
                    sda_oe_ff <= 1'h0;  // [RULE24]
                end
                default: begin
                    state_ff  <= ST_IDLE;
                    sda_oe_ff <= 1'h0;
                end
            endcase
        end
    end

    // Instruction bits are latched when the instruction byte completes.
    always_ff @(posedge ref_clk or negedge rst_ns) begin
        if (!rst_ns) begin
            rs_mode_ff  <= 1'h0;
            shutdown_ff <= 1'h0;
        end else if (state_ff == ST_INSTR && byte_done) begin
            // Bit seven and bits four to zero are don't care.
            rs_mode_ff  <= rx_byte[MIDSCALE_RESET_POS];  // [RULE6] [RULE18]
            shutdown_ff <= rx_byte[SHUTDOWN_POS];        // [RULE8] [RULE6]
        end
    end

    // Wiper register: power-on midscale, loaded by data bytes.
    always_ff @(posedge ref_clk or negedge rst_ns) begin
        if (!rst_ns) begin
            wiper_ff <= WIPER_MIDSCALE;  // [RULE22] [RULE21]
        end else if (state_ff == ST_INSTR && byte_done && rx_byte[MIDSCALE_RESET_POS]) begin
            // Midscale reset overwrites the stored code itself.
            wiper_ff <= WIPER_MIDSCALE;  // [RULE7] [RULE21]
        end else if (state_ff == ST_WDATA && byte_done) begin
            // Every data byte loads, with the instruction of this transfer;
            // shutdown does not block storage.
            if (rs_mode_ff) begin
                wiper_ff <= WIPER_MIDSCALE;  // [RULE7] [RULE17]
            end else begin
                wiper_ff <= rx_byte;  // [RULE11] [RULE17] [RULE10]
            end
        end
    end

    // Addressed flag and the constant low drive level of the data line.
    always_ff @(posedge ref_clk or negedge rst_ns) begin
        if (!rst_ns) begin
            addressed_ff <= 1'h0;
            sda_out_ff   <= 1'h0;
        end else begin
            addressed_ff <= (state_ff != ST_IDLE) && (state_ff != ST_ADDR) &&
                            (state_ff != ST_IGNORE);
            sda_out_ff   <= 1'h0;
        end
    end

    // Ladder decoder with shutdown switching.
    pws_ladder #(.TAPS(TAP_COUNT)) u_ladder (
        .ref_clk     (ref_clk),
        .rst_n       (rst_ns),
        .wiper_code  (wiper_ff),
        .shutdown    (shutdown_ff),
        .tap_select  (tap_select),
        .term_a_open (term_a_open),
        .wiper_to_b  (wiper_to_b)
    );

    // Outputs straight from flip-flops.
    assign sda_o           = sda_out_ff;
    assign sda_oe          = sda_oe_ff;
    assign wiper_register  = wiper_ff;
    assign shutdown_active = shutdown_ff;
    assign addressed       = addressed_ff;

endmodule

// File: pkg/pws_pkg.sv
// Shared constants and types for the potentiometer wiper serial slave.
package pws_pkg;

    // Upper six bits of the seven-bit target address.
    localparam logic [5:0] ADDR_UPPER    = 6'h16;
    // Width of the wiper register.
    localparam int         WIPER_W       = 8;
    // Number of ladder tap positions.
    localparam int         TAP_COUNT     = 256;
    // Midscale code, also the power-on preset of the wiper register.
    localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
    // Position of the midscale reset bit inside the instruction byte.
    localparam int         MIDSCALE_RESET_POS = 6;
    // Position of the shutdown bit inside the instruction byte.
    localparam int         SHUTDOWN_POS  = 5;
    // Bit counter value on the last data bit of a byte.
    localparam logic [3:0] BIT_LAST      = 4'h7;
    // Bit counter value once all eight data bits have been clocked.
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    // Reset levels of the synchronised bus lines (idle bus is high).
    localparam logic       LINE_IDLE     = 1'h1;
    // Reset level of the synchronised strap.
    localparam logic       STRAP_RST     = 1'h0;

    // Serial engine states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INSTR,
        ST_INSTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } pws_state_t;

endpackage

// File: core/pws_sync.sv
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module pws_sync
    import pws_pkg::*;
#(
    parameter logic RST_VAL = 1'h0
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Asynchronous level in, synchronised level out.
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_ff;  // First stage, read only by the second stage.
    logic sync_ff;  // Second stage, safe for logic to read.

    // Two-stage capture; only the second stage leaves the module.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// File: core/pws_ladder.sv
// Resistor ladder tap decoder with shutdown switching.
`timescale 1ns/1ps
module pws_ladder
    import pws_pkg::*;
#(
    parameter int TAPS = TAP_COUNT
) (
    // Clock and reset.
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // Stored wiper code and shutdown state.
    input  wire logic [WIPER_W-1:0] wiper_code,
    input  wire logic               shutdown,
    // Switch controls towards the analog ladder.
    output logic [TAPS-1:0]         tap_select,
    output logic                    term_a_open,
    output logic                    wiper_to_b
);

    logic [TAPS-1:0] tap_ff;      // One-hot tap selection.
    logic            a_open_ff;   // Terminal A disconnected.
    logic            w_to_b_ff;   // Wiper tied to terminal B.

    // Shutdown switches: the stored code is untouched, only the switches move.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_open_ff <= 1'h0;
            w_to_b_ff <= 1'h0;
        end else begin
            a_open_ff <= shutdown;  // [RULE8]
            w_to_b_ff <= shutdown;  // [RULE8]
        end
    end

    // One decoder bit per tap; tap zero is the B terminal contact.
    genvar t;
    generate
        for (t = 0; t < TAPS; t++) begin : g_tap
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    tap_ff[t] <= (t == int'(WIPER_MIDSCALE));
                end else if (shutdown) begin
                    tap_ff[t] <= (t == 0);  // [RULE8]
                end else begin
                    // Leaving shutdown re-applies the latest stored code.
                    tap_ff[t] <= (t == int'(wiper_code));  // [RULE23] [RULE9] [RULE10]
                end
            end
        end
    endgenerate

    assign tap_select  = tap_ff;
    assign term_a_open = a_open_ff;
    assign wiper_to_b  = w_to_b_ff;

endmodule

// File: bench/pws_slave_asserts.sv
// Concurrent checks on the ports of the potentiometer wiper serial slave.
`timescale 1ns/1ps
module pws_slave_asserts
    import pws_pkg::*;
(
    // Clock and reset.
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    // Serial bus pins.
    input wire logic                 scl_i,
    input wire logic                 sda_i,
    input wire logic                 sda_o,
    input wire logic                 sda_oe,
    input wire logic                 address_select_strap,
    // Wiper and ladder state.
    input wire logic [WIPER_W-1:0]   wiper_register,
    input wire logic                 shutdown_active,
    input wire logic                 addressed,
    input wire logic [TAP_COUNT-1:0] tap_select,
    input wire logic                 term_a_open,
    input wire logic                 wiper_to_b
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Shutdown held long enough for the ladder controls to follow it.
    sequence sd_on_s;
        shutdown_active[*4];
    endsequence
    sequence sd_off_s;
        !shutdown_active[*4];
    endsequence
    // Wiper code steady outside shutdown.
    sequence code_held_s;
        (!shutdown_active && $stable(wiper_register))[*4];
    endsequence

    chk_sd_opens_a: assert property (sd_on_s |-> term_a_open && wiper_to_b)
        else $error("ladder not switched for shutdown");
    chk_sd_off_closed: assert property (sd_off_s |-> !term_a_open && !wiper_to_b)
        else $error("ladder still switched after shutdown");
    chk_sd_tap_zero: assert property (sd_on_s |-> tap_select == 256'h1)
        else $error("tap not at B end in shutdown");
    chk_tap_follows: assert property (code_held_s |-> tap_select == (256'h1 << wiper_register))
        else $error("tap does not match wiper code");
    chk_oe_when_addr: assert property ($rose(sda_oe) |-> addressed)
        else $error("data line driven while not addressed");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line changed while clock high");
    chk_oe_bit_span: assert property ($rose(sda_oe) |=> sda_oe[*8])
        else $error("data line drive shorter than a bit");
    chk_wiper_addr: assert property ($changed(wiper_register) |-> addressed)
        else $error("wiper changed outside a transfer");
    chk_reset_mid: assert property ($rose(rst_n) |-> wiper_register == 8'h80 && !sda_oe)
        else $error("wiper not at midscale after reset");
endmodule

// File: bench/pws_bus_master.sv
// Behavioural two-wire bus master for the wiper serial slave.
`timescale 1ns/1ps
module pws_bus_master (
    // Serial clock and data pull-down from the master.
    output logic      scl,
    output logic      sda_pull,
    // Resolved data line level.
    input  wire logic sda
);
    localparam realtime Q = 31.25; // Quarter of the 125 ns bit time.

    // Idle bus: clock high, data released.
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end

    // START, also usable as a repeated START.
    task automatic start();
        #1; // Step off the reference clock edge so no pin change races a sample.
        sda_pull = 1'h0;
        #Q scl = 1'h1;
        #Q sda_pull = 1'h1;
        #Q scl = 1'h0;
        #Q;
    endtask

    // STOP; the line is pulled low first so it rises with clock high.
    task automatic stop();
        sda_pull = 1'h1;
        #Q scl = 1'h1;
        #Q sda_pull = 1'h0;
        #(2*Q);
    endtask

    // One bit: data set while clock low, sampled mid-high.
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        #Q scl = 1'h1;
        #Q r = sda;
        #Q scl = 1'h0;
        #Q;
    endtask

    // Eight bits MSB first, then the acknowledge bit.
    task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                        output logic [7:0] rx, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_bit, a);
        acked = !a;
    endtask
endmodule

// File: bench/pws_slave_tb.sv
// Self-checking bench for the potentiometer wiper serial slave.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module pws_slave_tb;
    import pws_pkg::*;
    localparam logic [6:0] A0 = {6'h16, 1'h0}; // Address with strap low.
    localparam logic [6:0] A1 = {6'h16, 1'h1}; // Address with strap high.
    logic                 ref_clk, rst_n, strap, scl, m_pull;
    logic                 sda_o, sda_oe, shutdown_active, addressed, term_a_open, wiper_to_b;
    logic [WIPER_W-1:0]   wiper_register;
    logic [TAP_COUNT-1:0] tap_select;
    wire logic            sda_line;
    int                   n_fail = 0;
    int                   checked = 0;
    logic [7:0]           exp_w = 8'h80; // Expected wiper code.
    logic                 exp_sd = 1'h0; // Expected shutdown state.
    logic [7:0]           rx;
    logic                 ak;

    // Open-drain data line with pull-up.
    assign sda_line = !(m_pull || (sda_oe && !sda_o));

    pws_slave dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .address_select_strap(strap),
        .wiper_register(wiper_register), .shutdown_active(shutdown_active),
        .addressed(addressed), .tap_select(tap_select), .term_a_open(term_a_open),
        .wiper_to_b(wiper_to_b));
    pws_bus_master m (.scl(scl), .sda_pull(m_pull), .sda(sda_line));

    // 100 MHz clock.
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Compare the wiper and ladder state with the expectation.
    task automatic chk_state();
        `CHK("wiper_register", exp_w, wiper_register)
        `CHK("shutdown_active", exp_sd, shutdown_active)
        `CHK("ladder switches", {2{exp_sd}}, {term_a_open, wiper_to_b})
        `CHK("tap_select", exp_sd ? 256'h1 : (256'h1 << exp_w), tap_select)
        `CHK("addressed idle", 1'h0, addressed)
        `CHK("sda_oe released", 1'h0, sda_oe)
    endtask

    // Write transfer: address, instruction, nd data bytes, STOP.
    task automatic wr_tx(input logic [6:0] a, input logic [7:0] ins, d0, d1,
                         input int nd, input logic hit);
        m.start();
        m.xfer({a, 1'h0}, 1'h1, rx, ak);
        `CHK("address ack", hit, ak)
        m.xfer(ins, 1'h1, rx, ak);
        `CHK("instruction ack", hit, ak)
        if (hit) begin
            exp_sd = ins[5];
            if (ins[6]) exp_w = 8'h80;
        end
        for (int k = 0; k < nd; k++) begin
            m.xfer(k ? d1 : d0, 1'h1, rx, ak);
            `CHK("data ack", hit, ak)
            if (hit) exp_w = ins[6] ? 8'h80 : (k ? d1 : d0);
            repeat (2) @(posedge ref_clk);
            #1; // Off the edge: outputs settled, and the next bit starts off an edge.
            `CHK("wiper after byte", exp_w, wiper_register)
            `CHK("addressed in transfer", hit, addressed)
        end
        m.stop();
        repeat (4) @(posedge ref_clk);
        chk_state();
    endtask

    // Read transfer of n bytes, the last one refused by the master.
    task automatic rd_tx(input logic [6:0] a, input int n, input logic hit);
        m.start();
        m.xfer({a, 1'h1}, 1'h1, rx, ak);
        `CHK("read address ack", hit, ak)
        for (int k = 0; hit && k < n; k++) begin
            m.xfer(8'hff, k == n - 1, rx, ak);
            `CHK("read data", exp_w, rx)
        end
        m.stop();
        repeat (4) @(posedge ref_clk);
    endtask

    // Print the verdict and end the run.
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence.
    initial begin
        rst_n = 1'h0;
        strap = 1'h0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (8) @(posedge ref_clk);
        chk_state();
        `CHK("sda_oe idle", 1'h0, sda_oe)
        wr_tx(A0, 8'h00, 8'h3c, 8'hc5, 2, 1'h1);
        rd_tx(A0, 1, 1'h1);
        rd_tx(A0, 3, 1'h1);
        wr_tx(A0, 8'h9f, 8'h11, 8'h00, 1, 1'h1);
        wr_tx(A0, 8'h20, 8'h42, 8'h00, 1, 1'h1);
        rd_tx(A0, 1, 1'h1);
        wr_tx(A0, 8'h00, 8'h00, 8'h00, 0, 1'h1);
        wr_tx(A0, 8'h40, 8'h11, 8'h22, 2, 1'h1);
        wr_tx(A0, 8'h00, 8'h00, 8'h00, 0, 1'h1);
        wr_tx(A1, 8'h00, 8'h5a, 8'h00, 1, 1'h0);
        rd_tx(A1, 1, 1'h0);
        strap <= 1'h1;
        repeat (6) @(posedge ref_clk);
        wr_tx(A0, 8'h00, 8'h5a, 8'h00, 1, 1'h0);
        wr_tx(A1, 8'h00, 8'h5a, 8'h00, 1, 1'h1);
        rd_tx(A1, 2, 1'h1);
        give_verdict();
    end

    // Watchdog well beyond the expected run time.
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        give_verdict();
    end
endmodule

bind pws_slave pws_slave_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_strap(address_select_strap), .wiper_register(wiper_register),
    .shutdown_active(shutdown_active), .addressed(addressed), .tap_select(tap_select),
    .term_a_open(term_a_open), .wiper_to_b(wiper_to_b));
